// ===== rtl/odtpd_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module odtpd_tracker #(
  parameter int DEPTH = odtpd_pkg::HIST_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        ck_in,                       // link clock from the controller
  input  wire logic        cke_in,                      // clock enable pin
  input  wire logic        odt_in,                      // termination request pin
  input  wire logic        refresh_in,                  // refresh command decoded at the pins
  input  wire logic        dll_on_in,                   // mode bit: dll kept on in power-down
  input  wire logic [4:0]  cwl_in,                      // cas write latency
  input  wire logic [4:0]  al_in,                       // additive latency
  output logic             powerdown_entry_window_out,  // entry window open
  output logic             powerdown_exit_window_out,   // exit window open
  output logic             transition_out,              // either response may occur
  output logic             async_out,                   // asynchronous response mode
  output logic             odt_int_out,                 // internal termination request
  output logic             case_sync_side_change_out,   // odt changed on the sync side
  output logic             case_in_window_change_out,   // odt changed inside a window
  output logic             case_async_side_change_out,  // odt changed on the async side
  output logic [23:0]      on_early_ps_out,             // earliest turn-on in a window
  output logic [23:0]      on_late_ps_out,              // latest turn-on in a window
  output logic [23:0]      off_early_ps_out,            // earliest turn-off in a window
  output logic [23:0]      off_late_ps_out              // latest turn-off in a window
);
  // whole state of the tracker
  typedef struct packed {
    logic [1:0]             ck_s;      // link clock synchroniser
    logic                   ck_q;      // previous synchronised link clock
    logic [1:0]             cke_s;     // cke synchroniser
    logic [1:0]             odt_s;     // odt synchroniser
    logic [1:0]             ref_s;     // refresh synchroniser
    logic [1:0]             dll_s;     // dll mode synchroniser
    logic [4:0]             cwl_s1;    // cwl first stage
    logic [4:0]             cwl_s2;    // cwl second stage
    logic [4:0]             al_s1;     // al first stage
    logic [4:0]             al_s2;     // al second stage
    logic                   step_q;    // history updated last cycle
    logic [7:0]             rfc_cnt;   // refresh still running, delayed frame
    logic [7:0]             xp_cnt;    // exit window tail, delayed frame
    logic                   entry_hold;// entry stretched by refresh
    odtpd_pkg::odtpd_mode_t mode;      // current response mode
    logic                   entry_win;
    logic                   exit_win;
    logic                   trans;
    logic                   odt_int;
    logic                   c_sync;
    logic                   c_win;
    logic                   c_async;
    logic [23:0]            on_early;
    logic [23:0]            on_late;
    logic [23:0]            off_early;
    logic [23:0]            off_late;
  } odtpd_state_t;

  odtpd_state_t st;      // registered state
  odtpd_state_t next_st; // next state

  odtpd_hist_if #(.DEPTH(DEPTH)) hist ();

  logic [5:0] lead;       // window lead in link clocks
  logic [5:0] lat;        // synchronous latency in link clocks
  logic       dll_off;    // windows apply
  logic       fall_ahead; // cke falls within the lead
  logic       rise_ahead; // cke rises within the lead
  logic       del_fall;   // cke falls at the delayed point
  logic       del_rise;   // cke rises at the delayed point
  logic       del_cke;    // cke at the delayed point
  logic       del_odt;    // odt at the delayed point
  logic       sync_odt;   // odt one sync latency behind the delayed point
  logic       odt_chg;    // odt changed at the delayed point

  ////////////////////////////////////////////////////////////////////////
  // delayed-frame view: the output frame lags the pins by the lead, so a
  // window that opens ahead of a cke edge can be shown without guessing
  always_comb begin
    lat        = 6'({1'b0, st.cwl_s2} + {1'b0, st.al_s2}) - odtpd_pkg::LAT_OFS;
    lead       = 6'({1'b0, st.cwl_s2} + {1'b0, st.al_s2}) - odtpd_pkg::LEAD_OFS;
    dll_off    = ~st.dll_s[1];
    fall_ahead = 1'b0;
    rise_ahead = 1'b0;
    del_fall   = 1'b0;
    del_rise   = 1'b0;
    for (int i = 0; i < DEPTH - 1; i++) begin
      // edge at index i: sample i+1 older than sample i
      if (i <= int'(lead)) begin
        fall_ahead = fall_ahead | (hist.h_cke[i+1] & ~hist.h_cke[i]);
        rise_ahead = rise_ahead | (~hist.h_cke[i+1] & hist.h_cke[i]);
      end
      if (i == int'(lead)) begin
        del_fall = hist.h_cke[i+1] & ~hist.h_cke[i];
        del_rise = ~hist.h_cke[i+1] & hist.h_cke[i];
      end
    end
    del_cke  = hist.h_cke[lead];
    del_odt  = hist.h_odt[lead];
    odt_chg  = hist.h_odt[lead] ^ hist.h_odt[lead + 6'h01];
    sync_odt = hist.h_odt[lead + lat];
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    int on_sync;
    int off_sync;
    on_sync  = 0;
    off_sync = 0;
    next_st  = st;
    // pins pass two flops; only the second stage is read further on
    next_st.ck_s   = {st.ck_s[0], ck_in};
    next_st.ck_q   = st.ck_s[1];
    next_st.cke_s  = {st.cke_s[0], cke_in};
    next_st.odt_s  = {st.odt_s[0], odt_in};
    next_st.ref_s  = {st.ref_s[0], refresh_in};
    next_st.dll_s  = {st.dll_s[0], dll_on_in};
    next_st.cwl_s1 = cwl_in;
    next_st.cwl_s2 = st.cwl_s1;
    next_st.al_s1  = al_in;
    next_st.al_s2  = st.al_s1;
    next_st.step_q = hist.step;
    next_st.c_sync  = 1'b0;
    next_st.c_win   = 1'b0;
    next_st.c_async = 1'b0;
    // turn-on and turn-off bounds for a change inside a window
    on_sync  = int'(lat) * odtpd_pkg::TCK_PS;
    off_sync = int'(lat) * odtpd_pkg::TCK_PS;
    next_st.on_early  = 24'(odtpd_pkg::AONPD_MIN_PS < on_sync + odtpd_pkg::AON_MIN_PS ?
                            odtpd_pkg::AONPD_MIN_PS : on_sync + odtpd_pkg::AON_MIN_PS);
    next_st.on_late   = 24'(odtpd_pkg::AONPD_MAX_PS > on_sync + odtpd_pkg::AON_MAX_PS ?
                            odtpd_pkg::AONPD_MAX_PS : on_sync + odtpd_pkg::AON_MAX_PS);
    next_st.off_early = 24'(odtpd_pkg::AOFPD_MIN_PS < off_sync + odtpd_pkg::AOF_MIN_PS ?
                            odtpd_pkg::AOFPD_MIN_PS : off_sync + odtpd_pkg::AOF_MIN_PS);
    next_st.off_late  = 24'(odtpd_pkg::AOFPD_MAX_PS > off_sync + odtpd_pkg::AOF_MAX_PS ?
                            odtpd_pkg::AOFPD_MAX_PS : off_sync + odtpd_pkg::AOF_MAX_PS);
    if (st.step_q) begin
      // refresh timer in the delayed frame
      if (hist.h_ref[lead]) begin
        next_st.rfc_cnt = odtpd_pkg::TRFC_CK;
      end else if (st.rfc_cnt != 8'h00) begin
        next_st.rfc_cnt = st.rfc_cnt - 8'h01;
      end
      // cke low while refresh runs: entry ends at the refresh end
      if (del_fall && st.rfc_cnt > 8'h01) begin
        next_st.entry_hold = 1'b1;
      end else if (st.rfc_cnt <= 8'h01) begin
        next_st.entry_hold = 1'b0;
      end
      // exit window tail after the cke high edge
      if (del_rise) begin
        next_st.xp_cnt = odtpd_pkg::TXPDLL_CK;
      end else if (st.xp_cnt != 8'h00) begin
        next_st.xp_cnt = st.xp_cnt - 8'h01;
      end
      next_st.entry_win = dll_off & (fall_ahead | next_st.entry_hold);
      // the tail reads the count from before this step, so it covers
      // the full txpdll clocks after the high edge, not one less
      next_st.exit_win  = dll_off & (rise_ahead | (st.xp_cnt != 8'h00));
      // overlapping windows merge into one span
      next_st.trans = next_st.entry_win | next_st.exit_win;
      // mode settles only once no window is open
      if (!dll_off) begin
        next_st.mode = odtpd_pkg::ODTPD_SYNC;
      end else if (!next_st.trans) begin
        next_st.mode = del_cke ? odtpd_pkg::ODTPD_SYNC : odtpd_pkg::ODTPD_ASYNC;
      end
      // termination request: async takes odt with no latency, sync waits the latency
      case (next_st.mode)
        odtpd_pkg::ODTPD_ASYNC: next_st.odt_int = del_odt;
        odtpd_pkg::ODTPD_SYNC:  next_st.odt_int = sync_odt;
        default:                next_st.odt_int = sync_odt;
      endcase
      // classify each odt change
      if (odt_chg) begin
        if (next_st.trans) begin
          next_st.c_win = 1'b1;
        end else if (next_st.mode == odtpd_pkg::ODTPD_ASYNC) begin
          next_st.c_async = 1'b1;
        end else begin
          next_st.c_sync = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset clears every field to zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // history feed, one sample per rising link clock edge
  assign hist.step = st.ck_s[1] & ~st.ck_q;
  assign hist.cke  = st.cke_s[1];
  assign hist.odt  = st.odt_s[1];
  assign hist.refr = st.ref_s[1];

  odtpd_hist #(.DEPTH(DEPTH)) u_hist (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .hist     (hist.store)
  );

  assign powerdown_entry_window_out = st.entry_win;
  assign powerdown_exit_window_out  = st.exit_win;
  assign transition_out             = st.trans;
  assign async_out                  = (st.mode == odtpd_pkg::ODTPD_ASYNC);
  assign odt_int_out                = st.odt_int;
  assign case_sync_side_change_out  = st.c_sync;
  assign case_in_window_change_out  = st.c_win;
  assign case_async_side_change_out = st.c_async;
  assign on_early_ps_out            = st.on_early;
  assign on_late_ps_out             = st.on_late;
  assign off_early_ps_out           = st.off_early;
  assign off_late_ps_out            = st.off_late;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  dll_gate_a: assert property (st.step_q && !dll_off |=> !st.entry_win && !st.exit_win)
    else $error("window open with dll kept on");
  entry_edge_a: assert property (st.step_q && dll_off && del_fall |=> st.entry_win)
    else $error("entry window not open at cke low edge");
  entry_lead_a: assert property (st.step_q && dll_off && fall_ahead |=> st.entry_win)
    else $error("entry window not open within lead");
  refresh_hold_a: assert property (st.step_q && del_fall && st.rfc_cnt > 8'h01 |=> st.entry_hold)
    else $error("refresh did not stretch entry window");
  exit_tail_a: assert property (st.step_q && dll_off && del_rise
    |=> st.exit_win && st.xp_cnt == odtpd_pkg::TXPDLL_CK)
    else $error("exit window tail not started");
  window_union_a: assert property (st.entry_win || st.exit_win |-> st.trans)
    else $error("window open without transition");
  async_side_a: assert property (st.c_async |-> st.mode == odtpd_pkg::ODTPD_ASYNC && !st.trans)
    else $error("async-side change outside async mode");
  sync_side_a: assert property (st.c_sync |-> st.mode == odtpd_pkg::ODTPD_SYNC && !st.trans)
    else $error("sync-side change outside sync mode");
  win_change_a: assert property (st.c_win |-> st.trans ##1 !st.c_win)
    else $error("in-window change flag wrong");
  async_follow_a: assert property (st.step_q |=> st.mode != odtpd_pkg::ODTPD_ASYNC
    || st.odt_int == $past(del_odt))
    else $error("async request does not follow odt");
  sync_follow_a: assert property (st.step_q |=> st.mode != odtpd_pkg::ODTPD_SYNC
    || st.odt_int == $past(sync_odt))
    else $error("sync request not delayed by latency");
  // bounds are zero straight out of reset, so the first cycle is skipped
  on_bound_a: assert property (!$past(reset_in) |-> st.on_early <= 24'(odtpd_pkg::AONPD_MIN_PS)
    && st.on_late >= 24'(odtpd_pkg::AONPD_MAX_PS))
    else $error("turn-on bounds too narrow");
  off_bound_a: assert property (!$past(reset_in) |-> st.off_early <= 24'(odtpd_pkg::AOFPD_MIN_PS)
    && st.off_late >= 24'(odtpd_pkg::AOFPD_MAX_PS))
    else $error("turn-off bounds too narrow");
endmodule : odtpd_tracker
`default_nettype wire

// ===== shared/odtpd_pkg.sv
`default_nettype none
package odtpd_pkg;
  // depth of the per-edge history, in link clock edges
  localparam int HIST_DEPTH   = 48;
  // link clock period, in ps
  localparam int TCK_PS       = 400000;
  // refresh cycle time and dll-off power-down exit time, in ps
  localparam int TRFC_PS      = 2000000;
  localparam int TXPDLL_PS    = 24000;
  // least times round up to whole link clocks, never below one
  localparam int TRFC_CK_I    = (TRFC_PS + TCK_PS - 1) / TCK_PS;
  localparam int TXPDLL_CK_I  = (TXPDLL_PS + TCK_PS - 1) / TCK_PS;
  localparam logic [7:0] TRFC_CK   = 8'(TRFC_CK_I < 1 ? 1 : TRFC_CK_I);
  localparam logic [7:0] TXPDLL_CK = 8'(TXPDLL_CK_I < 1 ? 1 : TXPDLL_CK_I);
  // asynchronous turn-on / turn-off delay bounds, in ps
  localparam int AONPD_MIN_PS = 1000;
  localparam int AONPD_MAX_PS = 9000;
  localparam int AOFPD_MIN_PS = 1000;
  localparam int AOFPD_MAX_PS = 9000;
  // synchronous turn-on skew around the latency, in ps
  localparam int AON_MIN_PS   = 0;
  localparam int AON_MAX_PS   = 400;
  // synchronous turn-off skew: 0.5 tck minus / plus 0.2 tck
  localparam int AOF_MIN_PS   = (TCK_PS * 3) / 10;
  localparam int AOF_MAX_PS   = (TCK_PS * 7) / 10;
  // latency offsets: window lead is wl - 1, sync latency is wl - 2
  localparam logic [5:0] LEAD_OFS = 6'h01;
  localparam logic [5:0] LAT_OFS  = 6'h02;
  // termination response mode
  typedef enum logic {ODTPD_SYNC, ODTPD_ASYNC} odtpd_mode_t;
endpackage : odtpd_pkg
`default_nettype wire

// ===== shared/odtpd_hist_if.sv
`timescale 1ns/1ps
`default_nettype none
interface odtpd_hist_if #(parameter int DEPTH = 48);
  logic             step;  // one-cycle strobe: a link clock edge was seen
  logic             cke;   // cke registered at that edge
  logic             odt;   // odt registered at that edge
  logic             refr;  // refresh command registered at that edge
  logic [DEPTH-1:0] h_cke; // cke history, bit 0 newest
  logic [DEPTH-1:0] h_odt; // odt history, bit 0 newest
  logic [DEPTH-1:0] h_ref; // refresh history, bit 0 newest
  modport writer (output step, cke, odt, refr, input h_cke, h_odt, h_ref);
  modport store  (input step, cke, odt, refr, output h_cke, h_odt, h_ref);
endinterface : odtpd_hist_if
`default_nettype wire

// ===== rtl/odtpd_hist.sv
`timescale 1ns/1ps
`default_nettype none
module odtpd_hist #(
  parameter int DEPTH = 48
) (
  input  wire logic   clk_in,
  input  wire logic   reset_in,
  odtpd_hist_if.store hist
);
  // all history lives in one struct
  typedef struct packed {
    logic [DEPTH-1:0] cke;
    logic [DEPTH-1:0] odt;
    logic [DEPTH-1:0] refr;
  } odtpd_hist_t;

  odtpd_hist_t st;      // registered history
  odtpd_hist_t next_st; // next history

  ////////////////////////////////////////////////////////////////////////
  // shift one sample per link clock edge, newest into bit 0
  always_comb begin
    next_st = st;
    if (hist.step) begin
      next_st.cke  = {st.cke[DEPTH-2:0], hist.cke};
      next_st.odt  = {st.odt[DEPTH-2:0], hist.odt};
      next_st.refr = {st.refr[DEPTH-2:0], hist.refr};
    end
  end

  // cke history resets high so no false falling edge appears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '{cke: '1, odt: '0, refr: '0};
    end else begin
      st <= next_st;
    end
  end

  assign hist.h_cke = st.cke;
  assign hist.h_odt = st.odt;
  assign hist.h_ref = st.refr;

  // history moves only on a step
  hist_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !hist.step |=> st == $past(st)) else $error("history moved without a step");
endmodule : odtpd_hist
`default_nettype wire

// ===== verif/odtpd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// controller side: free-running link clock and the pins it drives
module odtpd_ctrl_model (
  output logic ck_out,      // link clock, 400 ns period
  output logic cke_out,     // clock enable pin
  output logic odt_out,     // termination request pin
  output logic refresh_out  // refresh command
);
  // link clock runs free, phase unrelated to the system clock
  initial begin
    ck_out = 1'b0;
    #13;
    forever #200 ck_out = ~ck_out;
  end
  // pins idle: clock enabled, no termination, no refresh
  initial begin
    cke_out     = 1'b1;
    odt_out     = 1'b0;
    refresh_out = 1'b0;
  end
  // one registered edge: change after the fall, hold across the rise
  // the bench keeps the cke, odt and refresh history; this model keeps none
  task automatic put(input logic c, input logic o, input logic r);
    @(negedge ck_out);
    cke_out     = c;
    odt_out     = o;
    refresh_out = r;
    @(posedge ck_out);
  endtask : put
endmodule : odtpd_ctrl_model
`default_nettype wire

// ===== verif/test_odtpd_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module test_odtpd_tracker;
  logic        clk_in, reset_in, dll_on_in;    // bench-driven inputs
  logic [4:0]  cwl_in, al_in;                  // latency settings
  wire logic   ck, cke, odt, refr;             // controller pins
  logic        ent, ext, trn, asy, oint;       // window and mode outputs
  logic        cs, cw, ca;                     // change class pulses
  logic [23:0] one, onl, ofe, ofl;             // bounds in ps
  int          n_fail = 0, check_count = 0, cyc = 0;
  int          cnt_s, cnt_w, cnt_a, exp_s, exp_w, exp_a, lead, lat;
  logic        pc[$], po[$], pr[$];            // per-edge pin history
  logic        exp_async;                      // expected mode, held in windows
  odtpd_ctrl_model u_ctrl (.ck_out(ck), .cke_out(cke), .odt_out(odt), .refresh_out(refr));
  odtpd_tracker u_dut (.clk_in(clk_in), .reset_in(reset_in), .ck_in(ck), .cke_in(cke),
    .odt_in(odt), .refresh_in(refr), .dll_on_in(dll_on_in), .cwl_in(cwl_in), .al_in(al_in),
    .powerdown_entry_window_out(ent), .powerdown_exit_window_out(ext), .transition_out(trn),
    .async_out(asy), .odt_int_out(oint), .case_sync_side_change_out(cs),
    .case_in_window_change_out(cw), .case_async_side_change_out(ca), .on_early_ps_out(one),
    .on_late_ps_out(onl), .off_early_ps_out(ofe), .off_late_ps_out(ofl));
  ////////////////////////////////////////////////////////////////
  // system clock, 50 ns
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // counts class pulses and cuts a hang short
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cs === 1'b1) cnt_s <= cnt_s + 1;
    if (cw === 1'b1) cnt_w <= cnt_w + 1;
    if (ca === 1'b1) cnt_a <= cnt_a + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: timeout", $time);
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  // compare tasks
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////
  // reference: pin history lookups, idle before the pattern
  function automatic logic gc(input int p);
    return (p < 0) ? 1'b1 : pc[p];
  endfunction : gc
  function automatic logic go(input int p);
    return (p < 0) ? 1'b0 : po[p];
  endfunction : go
  // entry window: lead edges before a first-low cke edge through it,
  // held to the end of a refresh that still runs at that edge
  function automatic logic in_ent(input int p);
    logic w;
    w = 1'b0;
    for (int f = p; f <= p + lead; f++) if (gc(f) == 1'b0 && gc(f - 1) == 1'b1) w = 1'b1;
    for (int r = p - int'(odtpd_pkg::TRFC_CK) + 1; r < p; r++)
      if (r >= 0 && pr[r])
        for (int f = r + 1; f <= p; f++) if (gc(f) == 1'b0 && gc(f - 1) == 1'b1) w = 1'b1;
    return w & ~dll_on_in;
  endfunction : in_ent
  // exit window: lead edges before a first-high edge, then txpdll more
  function automatic logic in_ext(input int p);
    logic w;
    w = 1'b0;
    for (int h = p - int'(odtpd_pkg::TXPDLL_CK); h <= p + lead; h++)
      if (gc(h) == 1'b1 && gc(h - 1) == 1'b0) w = 1'b1;
    return w & ~dll_on_in;
  endfunction : in_ext
  ////////////////////////////////////////////////////////////////
  // drivers
  task automatic setup(input logic dll, input int cwl, input int al);
    @(posedge clk_in);
    reset_in  <= 1'b1;
    dll_on_in <= dll;
    cwl_in    <= 5'(cwl);
    al_in     <= 5'(al);
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    {cnt_s, cnt_w, cnt_a, exp_s, exp_w, exp_a} = '0;
    lead = cwl + al - 1;
    lat  = cwl + al - 2;
    exp_async = 1'b0;
    pc.delete();
    po.delete();
    pr.delete();
  endtask : setup
  task automatic add(input int cnt, input logic c, input logic o, input logic r);
    repeat (cnt) begin
      pc.push_back(c);
      po.push_back(o);
      pr.push_back(r);
    end
  endtask : add
  // judges the outputs for edge n, which settled before the next rise
  task automatic check_edge(input int n);
    int   p;
    logic e, x, t, st;
    p = n - lead;
    e = in_ent(p);
    x = in_ext(p);
    t = e | x;
    if (!t) exp_async = ~dll_on_in & ~gc(p);
    if (go(p) != go(p - 1)) begin
      if (t) exp_w++;
      else if (exp_async) exp_a++;
      else exp_s++;
    end
    chk_bit(ent, e, "entry window");
    chk_bit(ext, x, "exit window");
    chk_bit(trn, t, "transition");
    chk_bit(asy, exp_async, "async mode");
    st = 1'b1;
    for (int k = p - lat; k <= p; k++) if (in_ent(k) | in_ext(k) | (gc(k) != gc(p))) st = 1'b0;
    if (st) chk_bit(oint, exp_async ? go(p) : go(p - lat), "internal odt");
  endtask : check_edge
  task automatic run_pat(input string name);
    add(lead + lat + 4, 1'b1, 1'b0, 1'b0);
    for (int n = 0; n < pc.size(); n++) begin
      u_ctrl.put(pc[n], po[n], pr[n]);
      if (n > 0) check_edge(n - 1);
    end
    repeat (8) @(posedge clk_in);
    chk_val(24'(cnt_s), 24'(exp_s), "sync side changes");
    chk_val(24'(cnt_w), 24'(exp_w), "in window changes");
    chk_val(24'(cnt_a), 24'(exp_a), "async side changes");
    $display("test %s done", name);
  endtask : run_pat
  // full power-down cycle with odt changes on every side of both windows
  task automatic pd_pattern();
    add(20, 1'b1, 1'b0, 1'b0);
    add(3, 1'b1, 1'b1, 1'b0);
    add(12, 1'b1, 1'b0, 1'b0);
    add(2, 1'b1, 1'b1, 1'b0);
    add(13, 1'b0, 1'b0, 1'b0);
    add(3, 1'b0, 1'b1, 1'b0);
    add(7, 1'b0, 1'b0, 1'b0);
    add(2, 1'b0, 1'b1, 1'b0);
    add(1, 1'b1, 1'b1, 1'b0);
    add(20, 1'b1, 1'b0, 1'b0);
    add(3, 1'b1, 1'b1, 1'b0);
  endtask : pd_pattern
  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_bounds();
    int cw[3] = '{5, 6, 8};
    int ad[3] = '{0, 2, 3};
    int l;
    setup(1'b0, 5, 0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      cwl_in <= 5'(cw[i]);
      al_in  <= 5'(ad[i]);
      repeat (8) @(posedge clk_in);
      l = (cw[i] + ad[i] - 2) * odtpd_pkg::TCK_PS;
      chk_val(one, 24'((odtpd_pkg::AONPD_MIN_PS < l + odtpd_pkg::AON_MIN_PS) ? odtpd_pkg::AONPD_MIN_PS
        : l + odtpd_pkg::AON_MIN_PS), "turn-on early");
      chk_val(onl, 24'((odtpd_pkg::AONPD_MAX_PS > l + odtpd_pkg::AON_MAX_PS) ? odtpd_pkg::AONPD_MAX_PS
        : l + odtpd_pkg::AON_MAX_PS), "turn-on late");
      chk_val(ofe, 24'((odtpd_pkg::AOFPD_MIN_PS < l + odtpd_pkg::AOF_MIN_PS) ? odtpd_pkg::AOFPD_MIN_PS
        : l + odtpd_pkg::AOF_MIN_PS), "turn-off early");
      chk_val(ofl, 24'((odtpd_pkg::AOFPD_MAX_PS > l + odtpd_pkg::AOF_MAX_PS) ? odtpd_pkg::AOFPD_MAX_PS
        : l + odtpd_pkg::AOF_MAX_PS), "turn-off late");
    end
    $display("test bounds done");
  endtask : s_bounds
  task automatic s_pd_dll_off();
    setup(1'b0, 6, 2);
    pd_pattern();
    run_pat("dll off cycle");
  endtask : s_pd_dll_off
  // dll kept on: no windows, response stays synchronous
  task automatic s_pd_dll_on();
    setup(1'b1, 5, 0);
    pd_pattern();
    run_pat("dll on cycle");
  endtask : s_pd_dll_on
  // short low pulse with an odt change inside the overlap
  task automatic s_short_low();
    setup(1'b0, 5, 0);
    add(20, 1'b1, 1'b0, 1'b0);
    add(2, 1'b0, 1'b1, 1'b0);
    add(20, 1'b1, 1'b0, 1'b0);
    run_pat("short low pulse");
  endtask : s_short_low
  // short high pulse between two power-downs
  task automatic s_short_high();
    setup(1'b0, 5, 0);
    add(20, 1'b1, 1'b0, 1'b0);
    add(15, 1'b0, 1'b0, 1'b0);
    add(2, 1'b1, 1'b1, 1'b0);
    add(15, 1'b0, 1'b0, 1'b0);
    run_pat("short high pulse");
  endtask : s_short_high
  // refresh just before cke falls
  task automatic s_refresh();
    setup(1'b0, 5, 1);
    add(20, 1'b1, 1'b0, 1'b0);
    add(1, 1'b1, 1'b0, 1'b1);
    add(15, 1'b0, 1'b1, 1'b0);
    run_pat("refresh before entry");
  endtask : s_refresh
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_in  = 1'b1;
    dll_on_in = 1'b0;
    cwl_in    = 5'h05;
    al_in     = 5'h00;
    repeat (10) @(posedge clk_in);
    s_bounds();
    s_pd_dll_off();
    s_pd_dll_on();
    s_short_low();
    s_short_high();
    s_refresh();
    test_done();
  end
endmodule : test_odtpd_tracker
`default_nettype wire
